// ### rtl/hdt_defs.vh
// constants for the host to drive-bus translator
// Notes on behaviour
// - exactly one mode at a time: configuration or cyclic update
// - configuration mode relays each relay request to the bus and back
// - host attach reset restores parameters and enters configuration mode
// - configuration requests need only a drive id, no registration
// - discovery probes every valid id and reports which answered
// - register request probes id; answering drive is listed and acknowledged
// - begin enters update mode and starts cyclic frames immediately
// - fresh flag set once every listed drive has answered, or 10 ms after begin even without data
// - latest position, velocity, torque, error flags kept per drive
// - cyclic rate set by number of listed drives
// - end closes both sides, returns to configuration, begin may resume
// - bus data rate selectable among 1, 2, 5 and 8 Mbps
`ifndef HDT_DEFS_VH
`define HDT_DEFS_VH
`define HDT_CLK_MHZ        125
`define HDT_FRESH_MS       10
`define HDT_FRESH_CYC      (`HDT_FRESH_MS * 1000 * `HDT_CLK_MHZ)
`define HDT_RESP_TMO_US    100
`define HDT_RESP_TMO_CYC   (`HDT_RESP_TMO_US * `HDT_CLK_MHZ)
// host request opcodes
`define HDT_OP_RELAY       3'h0
`define HDT_OP_DISCOVER    3'h1
`define HDT_OP_REGISTER    3'h2
`define HDT_OP_BEGIN       3'h3
`define HDT_OP_END         3'h4
`define HDT_OP_RATE        3'h5
// host answer status
`define HDT_ST_OK          2'h0
`define HDT_ST_NOANSWER    2'h1
`define HDT_ST_REFUSED     2'h2
// data rate codes: 1, 2, 5, 8 Mbps
`define HDT_RATE_1M        2'h0
`define HDT_RATE_2M        2'h1
`define HDT_RATE_5M        2'h2
`define HDT_RATE_8M        2'h3
`define HDT_RATE_RST       2'h0
`endif

// ### rtl/hdt_timer.v
// down-counting timeout timer
`timescale 1ns/100ps
module hdt_timer #(
  parameter W = 24
) (
  // clock and reset
  input  wire         clk,
  input  wire         reset,
  // control
  input  wire         start,
  input  wire [W-1:0] load,
  input  wire         stop,
  // status
  output reg          expired
);
  reg [W-1:0] cnt_q;
  reg         run_q;

  always @(posedge clk)
  begin
    if (reset)
    begin
      cnt_q   <= {W{1'b0}};
      run_q   <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (start)
      begin
        cnt_q <= load;
        run_q <= 1'b1;
      end
      else if (stop)
        run_q <= 1'b0;
      else if (run_q)
      begin
        if (cnt_q == {W{1'b0}})
        begin
          run_q   <= 1'b0;
          expired <= 1'b1;
        end
        else
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ### rtl/hdt_drive_store.v
// per-drive store of latest response data
`timescale 1ns/100ps
module hdt_drive_store #(
  parameter IDW = 4,
  parameter DW  = 32,
  parameter EW  = 16
) (
  // clock
  input  wire           clk,
  // write from bus responses
  input  wire           wr,
  input  wire [IDW-1:0] wr_slot,
  input  wire [DW-1:0]  wr_pos,
  input  wire [DW-1:0]  wr_vel,
  input  wire [DW-1:0]  wr_trq,
  input  wire [EW-1:0]  wr_err,
  // read by host
  input  wire [IDW-1:0] rd_slot,
  output reg  [DW-1:0]  rd_pos,
  output reg  [DW-1:0]  rd_vel,
  output reg  [DW-1:0]  rd_trq,
  output reg  [EW-1:0]  rd_err
);
  localparam N = 1 << IDW;
  reg [DW-1:0] pos_m [0:N-1];
  reg [DW-1:0] vel_m [0:N-1];
  reg [DW-1:0] trq_m [0:N-1];
  reg [EW-1:0] err_m [0:N-1];

  always @(posedge clk)
  begin
    if (wr)
    begin
      pos_m[wr_slot] <= wr_pos;
      vel_m[wr_slot] <= wr_vel;
      trq_m[wr_slot] <= wr_trq;
      err_m[wr_slot] <= wr_err;
    end
    rd_pos <= pos_m[rd_slot];
    rd_vel <= vel_m[rd_slot];
    rd_trq <= trq_m[rd_slot];
    rd_err <= err_m[rd_slot];
  end
endmodule

// ### rtl/hdt_translator.v
// host to drive-bus translator top
`timescale 1ns/100ps
`include "hdt_defs.vh"
module hdt_translator #(
  parameter IDW       = 4,
  parameter DW        = 32,
  parameter EW        = 16,
  parameter PW        = 64,
  parameter FRESH_CYC = `HDT_FRESH_CYC,
  parameter TMO_CYC   = `HDT_RESP_TMO_CYC
) (
  // clock and reset
  input  wire           clk,
  input  wire           reset,
  // host request
  input  wire           req_valid,
  input  wire [2:0]     req_op,
  input  wire [IDW-1:0] req_id,
  input  wire [PW-1:0]  req_payload,
  // host answer
  output reg            ans_valid,
  output reg  [1:0]     ans_status,
  output reg  [PW-1:0]  ans_payload,
  output reg  [(1<<IDW)-1:0] ans_id_map,
  // mode and status
  output reg            update_mode_q,
  output reg            fresh_q,
  output reg  [1:0]     rate_q,
  output reg  [IDW:0]   list_count_q,
  // host data read
  input  wire [IDW-1:0] rd_slot,
  output wire [DW-1:0]  rd_pos,
  output wire [DW-1:0]  rd_vel,
  output wire [DW-1:0]  rd_trq,
  output wire [EW-1:0]  rd_err,
  // drive bus frame port
  output reg            tx_valid,
  output reg  [IDW-1:0] tx_id,
  output reg  [PW-1:0]  tx_payload,
  input  wire           tx_ready,
  input  wire           rx_valid,
  input  wire [IDW-1:0] rx_id,
  input  wire [PW-1:0]  rx_payload,
  input  wire [DW-1:0]  rx_pos,
  input  wire [DW-1:0]  rx_vel,
  input  wire [DW-1:0]  rx_trq,
  input  wire [EW-1:0]  rx_err
);
  localparam N = 1 << IDW;
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_SEND = 7'h02;
  localparam [6:0] S_WAIT = 7'h04;
  localparam [6:0] S_DONE = 7'h08;
  localparam [6:0] S_CSEL = 7'h10;
  localparam [6:0] S_CSND = 7'h20;
  localparam [6:0] S_CWT  = 7'h40;
  localparam [1:0] K_RELAY = 2'h0;
  localparam [1:0] K_DISC  = 2'h1;
  localparam [1:0] K_REG   = 2'h2;

  reg [6:0]     st_q;
  reg [1:0]     kind_q;
  reg [IDW-1:0] id_q;
  reg [PW-1:0]  pay_q;
  reg [N-1:0]   list_q;
  reg [N-1:0]   seen_q;
  reg [N-1:0]   found_q;
  reg           got_q;
  reg           end_q;
  reg [31:0]    fresh_cnt_q;
  reg           tmr_start;
  wire          tmr_exp;

  function [IDW-1:0] next_listed;
    input [N-1:0]   map;
    input [IDW-1:0] cur;
    integer k;
    reg found;
    reg [IDW-1:0] c;
    begin
      found = 1'b0;
      next_listed = cur;
      for (k = 1; k <= N; k = k + 1)
      begin
        c = cur + k[IDW-1:0];
        if (!found && map[c])
        begin
          found = 1'b1;
          next_listed = c;
        end
      end
    end
  endfunction

  function [IDW:0] pop;
    input [N-1:0] map;
    integer k;
    begin
      pop = {(IDW+1){1'b0}};
      for (k = 0; k < N; k = k + 1)
        pop = pop + {{IDW{1'b0}}, map[k]};
    end
  endfunction

  wire rx_hit = rx_valid && (rx_id == id_q);

  hdt_timer #(.W(32)) u_tmo (
    .clk     (clk),
    .reset   (reset),
    .start   (tmr_start),
    .load    (TMO_CYC),
    .stop    (rx_hit),
    .expired (tmr_exp)
  );

  hdt_drive_store #(.IDW(IDW), .DW(DW), .EW(EW)) u_store (
    .clk     (clk),
    .wr      (rx_valid && list_q[rx_id] && update_mode_q),
    .wr_slot (rx_id),
    .wr_pos  (rx_pos),
    .wr_vel  (rx_vel),
    .wr_trq  (rx_trq),
    .wr_err  (rx_err),
    .rd_slot (rd_slot),
    .rd_pos  (rd_pos),
    .rd_vel  (rd_vel),
    .rd_trq  (rd_trq),
    .rd_err  (rd_err)
  );

  always @(posedge clk)
  begin
    if (reset)
    begin
      // host attach reset: known state, configuration mode
      st_q          <= S_IDLE;
      update_mode_q <= 1'b0;
      rate_q        <= `HDT_RATE_RST;
      list_q        <= {N{1'b0}};
      list_count_q  <= {(IDW+1){1'b0}};
      seen_q        <= {N{1'b0}};
      found_q       <= {N{1'b0}};
      fresh_q       <= 1'b0;
      fresh_cnt_q   <= 32'h0;
      kind_q        <= K_RELAY;
      id_q          <= {IDW{1'b0}};
      pay_q         <= {PW{1'b0}};
      got_q         <= 1'b0;
      end_q         <= 1'b0;
      ans_valid     <= 1'b0;
      ans_status    <= `HDT_ST_OK;
      ans_payload   <= {PW{1'b0}};
      ans_id_map    <= {N{1'b0}};
      tx_valid      <= 1'b0;
      tx_id         <= {IDW{1'b0}};
      tx_payload    <= {PW{1'b0}};
      tmr_start     <= 1'b0;
    end
    else
    begin
      ans_valid <= 1'b0;
      tmr_start <= 1'b0;
      list_count_q <= pop(list_q);
      if (update_mode_q && !fresh_q)
      begin
        if (fresh_cnt_q >= FRESH_CYC)
          fresh_q <= 1'b1;
        else
          fresh_cnt_q <= fresh_cnt_q + 32'h1;
        if ((seen_q & list_q) == list_q)
          fresh_q <= 1'b1;
      end
      if (rx_valid && update_mode_q)
        seen_q[rx_id] <= 1'b1;
      // requests during update mode: only end passes
      if (req_valid && update_mode_q && req_op != `HDT_OP_END)
      begin
        ans_valid  <= 1'b1;
        ans_status <= `HDT_ST_REFUSED;
      end
      else if (req_valid && update_mode_q)
        end_q <= 1'b1;
      case (st_q)
        S_IDLE:
        begin
          if (req_valid && !update_mode_q)
          begin
            id_q  <= req_id;
            pay_q <= req_payload;
            case (req_op)
              `HDT_OP_RELAY:
              begin
                kind_q <= K_RELAY;
                st_q   <= S_SEND;
              end
              `HDT_OP_DISCOVER:
              begin
                kind_q  <= K_DISC;
                id_q    <= {IDW{1'b0}};
                found_q <= {N{1'b0}};
                st_q    <= S_SEND;
              end
              `HDT_OP_REGISTER:
              begin
                kind_q <= K_REG;
                st_q   <= S_SEND;
              end
              `HDT_OP_BEGIN:
              begin
                update_mode_q <= 1'b1;
                fresh_q       <= 1'b0;
                fresh_cnt_q   <= 32'h0;
                seen_q        <= {N{1'b0}};
                end_q         <= 1'b0;
                ans_valid     <= 1'b1;
                ans_status    <= `HDT_ST_OK;
                id_q          <= next_listed(list_q, {IDW{1'b1}});
                st_q          <= S_CSEL;
              end
              `HDT_OP_RATE:
              begin
                rate_q     <= req_payload[1:0];
                ans_valid  <= 1'b1;
                ans_status <= `HDT_ST_OK;
              end
              default:
              begin
                ans_valid  <= 1'b1;
                ans_status <= `HDT_ST_OK;
              end
            endcase
          end
        end
        S_SEND:
        begin
          tx_valid   <= 1'b1;
          tx_id      <= id_q;
          tx_payload <= pay_q;
          if (tx_valid && tx_ready)
          begin
            tx_valid  <= 1'b0;
            got_q     <= 1'b0;
            tmr_start <= 1'b1;
            st_q      <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (rx_hit)
          begin
            got_q       <= 1'b1;
            ans_payload <= rx_payload;
            st_q        <= S_DONE;
          end
          else if (tmr_exp)
            st_q <= S_DONE;
        end
        S_DONE:
        begin
          if (kind_q == K_DISC && id_q != {IDW{1'b1}})
          begin
            found_q[id_q] <= got_q;
            id_q          <= id_q + {{(IDW-1){1'b0}}, 1'b1};
            st_q          <= S_SEND;
          end
          else
          begin
            if (kind_q == K_DISC)
              ans_id_map <= found_q | ({{(N-1){1'b0}}, got_q} << id_q);
            if (kind_q == K_REG && got_q)
              list_q[id_q] <= 1'b1;
            ans_valid  <= 1'b1;
            ans_status <= (got_q || kind_q == K_DISC) ? `HDT_ST_OK : `HDT_ST_NOANSWER;
            st_q       <= S_IDLE;
          end
        end
        S_CSEL:
        begin
          // finish the current slot before closing, so no frame is cut
          if (end_q || list_q == {N{1'b0}})
          begin
            if (end_q)
            begin
              update_mode_q <= 1'b0;
              end_q         <= 1'b0;
              ans_valid     <= 1'b1;
              ans_status    <= `HDT_ST_OK;
              st_q          <= S_IDLE;
            end
          end
          else
            st_q <= S_CSND;
        end
        S_CSND:
        begin
          tx_valid   <= 1'b1;
          tx_id      <= id_q;
          tx_payload <= pay_q;
          if (tx_valid && tx_ready)
          begin
            tx_valid  <= 1'b0;
            tmr_start <= 1'b1;
            st_q      <= S_CWT;
          end
        end
        S_CWT:
        begin
          if (rx_hit || tmr_exp)
          begin
            id_q <= next_listed(list_q, id_q);
            st_q <= S_CSEL;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ### tb/hdt_drive_model.sv
// far-side drive model, answers frames for ids set in PRES
`timescale 1ns/100ps
module hdt_drive_model #(
  parameter [15:0] PRES = 16'h0000,
  // watchdog span in cycles, 0 turns it off
  parameter        WD   = 250
) (
  // frame in
  input  wire        clk,
  input  wire        tx_valid,
  input  wire [3:0]  tx_id,
  input  wire [63:0] tx_payload,
  output reg         tx_ready,
  // answer out
  output reg         rx_valid,
  output reg  [3:0]  rx_id,
  output reg  [63:0] rx_payload,
  output reg  [31:0] rx_pos,
  output reg  [31:0] rx_vel,
  output reg  [31:0] rx_trq,
  output reg  [15:0] rx_err
);
  reg [1:0]  st_q;
  reg [1:0]  w_q;
  reg [3:0]  id_q;
  reg [63:0] pl_q;
  reg [15:0] wd_q;
  reg        armed_q;
  reg        off_q;
  initial
  begin
    {st_q, w_q, tx_ready, rx_valid, rx_id, rx_payload} = 0;
    {rx_pos, rx_vel, rx_trq, rx_err} = 0;
    {wd_q, armed_q, off_q} = 0;
  end
  always @(posedge clk)
  begin
    // idle lines toggle so stale data never looks valid
    {rx_id, rx_payload, rx_pos, rx_vel, rx_trq, rx_err} <=
      ~{rx_id, rx_payload, rx_pos, rx_vel, rx_trq, rx_err};
    rx_valid <= 1'b0;
    tx_ready <= 1'b0;
    // each accepted frame rearms the watchdog; a long gap sets off_q, bit 15 of rx_err, for good
    if (st_q == 2'h1 && tx_valid && w_q == tx_id[1:0])
    begin
      armed_q <= 1'b1;
      wd_q    <= 16'h0;
    end
    else if (armed_q && WD != 0 && wd_q < WD)
      wd_q <= wd_q + 16'h1;
    else if (armed_q && WD != 0)
      off_q <= 1'b1;
    case (st_q)
      2'h0: if (tx_valid) st_q <= 2'h1;
      2'h1:
        if (!tx_valid)
          st_q <= 2'h0;
        else if (w_q == tx_id[1:0])
        begin
          // ready delay follows id, so some answers are slow
          tx_ready <= 1'b1;
          id_q <= tx_id;
          pl_q <= tx_payload;
          w_q <= 2'h0;
          st_q <= 2'h2;
        end
        else
          w_q <= w_q + 2'h1;
      2'h2: st_q <= 2'h3;
      default:
      begin
        st_q <= 2'h0;
        if (PRES[id_q])
        begin
          rx_valid <= 1'b1;
          rx_id <= id_q;
          rx_payload <= ~pl_q;
          rx_pos <= {28'h0, id_q};
          rx_vel <= ~{28'h0, id_q};
          rx_trq <= {id_q, 28'h0};
          rx_err <= {off_q, 11'h0, id_q};
        end
      end
    endcase
  end
endmodule

// ### tb/hdt_translator_sva.sv
// port checker for the translator top
`timescale 1ns/100ps
module hdt_translator_sva #(
  parameter IDW       = 4,
  parameter PW        = 64,
  parameter FRESH_CYC = 200
) (
  // clock, reset, host side
  input wire           clk,
  input wire           reset,
  input wire           req_valid,
  input wire [2:0]     req_op,
  input wire [PW-1:0]  req_payload,
  input wire           ans_valid,
  input wire [1:0]     ans_status,
  input wire           update_mode_q,
  input wire           fresh_q,
  input wire [1:0]     rate_q,
  input wire [IDW:0]   list_count_q,
  // bus side
  input wire           tx_valid,
  input wire [IDW-1:0] tx_id,
  input wire [PW-1:0]  tx_payload,
  input wire           tx_ready
);
  wire       beg = req_valid && req_op == 3'h3;
  wire [1:0] rc  = req_payload[1:0];
  reg [31:0] wait_q;
  always @(posedge clk)
    if (reset || !update_mode_q || fresh_q)
      wait_q <= 32'h0;
    else
      wait_q <= wait_q + 32'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id)
    && $stable(tx_payload)) else $error("tx frame dropped before ready");
  a_begin_enter: assert property (beg && !update_mode_q |=> update_mode_q
    && ans_valid && ans_status == 2'h0) else $error("begin not taken");
  a_cfg_refused: assert property (req_valid && req_op != 3'h4 && update_mode_q
    |=> ans_valid && ans_status == 2'h2 && update_mode_q) else $error("not refused");
  a_rate_set: assert property (req_valid && req_op == 3'h5 && !update_mode_q
    |=> rate_q == $past(rc)) else $error("rate code not applied");
  a_reset_state: assert property (disable iff (1'b0) reset |=> !update_mode_q
    && rate_q == 2'h0 && list_count_q == 0 && !tx_valid) else $error("bad reset state");
  a_enter_cause: assert property ($rose(update_mode_q) |-> $past(beg))
    else $error("update mode without begin");
  a_cycle_start: assert property ($rose(update_mode_q) && list_count_q != 0
    |-> ##[0:4] tx_valid) else $error("no cyclic frame after begin");
  a_fresh_bound: assert property (wait_q <= FRESH_CYC + 2)
    else $error("fresh data late");
  a_list_frozen: assert property (update_mode_q && $past(update_mode_q)
    |-> $stable(list_count_q)) else $error("list changed in update mode");
  a_ans_pulse: assert property (ans_valid |=> !ans_valid) else $error("answer too long");
  c_begin: cover property (beg && !update_mode_q);
  c_refused: cover property (ans_valid && ans_status == 2'h2);
  c_fresh: cover property ($rose(fresh_q));
endmodule
bind hdt_translator hdt_translator_sva #(.IDW(IDW), .PW(PW), .FRESH_CYC(FRESH_CYC)) u_sva (
  .clk(clk), .reset(reset), .req_valid(req_valid), .req_op(req_op),
  .req_payload(req_payload), .ans_valid(ans_valid), .ans_status(ans_status),
  .update_mode_q(update_mode_q), .fresh_q(fresh_q), .rate_q(rate_q),
  .list_count_q(list_count_q), .tx_valid(tx_valid), .tx_id(tx_id),
  .tx_payload(tx_payload), .tx_ready(tx_ready));

// ### tb/hdt_translator_tb_top.sv
// self-checking bench for the translator
`timescale 1ns/100ps
module hdt_translator_tb_top;
  localparam [15:0] PRES = 16'h0204;
  localparam        FR   = 200;
  typedef struct packed {logic [2:0] op; logic [3:0] id; logic [1:0] st;} hdt_row_t;
  reg         clk, reset, req_valid;
  reg  [2:0]  req_op;
  reg  [3:0]  req_id, rd_slot;
  reg  [63:0] req_payload;
  wire        ans_valid, update_mode_q, fresh_q, tx_valid, tx_ready, rx_valid;
  wire [1:0]  ans_status, rate_q;
  wire [4:0]  list_count_q;
  wire [3:0]  tx_id, rx_id;
  wire [15:0] ans_id_map, rd_err, rx_err;
  wire [31:0] rd_pos, rd_vel, rd_trq, rx_pos, rx_vel, rx_trq;
  wire [63:0] ans_payload, tx_payload, rx_payload;
  integer     n_errors, check_count, i, k;
  hdt_row_t   rows [0:10];
  hdt_translator #(.FRESH_CYC(FR), .TMO_CYC(20)) DUT (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req_op(req_op), .req_id(req_id), .req_payload(req_payload),
    .ans_valid(ans_valid), .ans_status(ans_status), .ans_payload(ans_payload),
    .ans_id_map(ans_id_map), .update_mode_q(update_mode_q), .fresh_q(fresh_q),
    .rate_q(rate_q), .list_count_q(list_count_q), .rd_slot(rd_slot), .rd_pos(rd_pos),
    .rd_vel(rd_vel), .rd_trq(rd_trq), .rd_err(rd_err), .tx_valid(tx_valid),
    .tx_id(tx_id), .tx_payload(tx_payload), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_id(rx_id), .rx_payload(rx_payload), .rx_pos(rx_pos), .rx_vel(rx_vel),
    .rx_trq(rx_trq), .rx_err(rx_err));
  hdt_drive_model #(.PRES(PRES)) u_drv (.clk(clk), .tx_valid(tx_valid), .tx_id(tx_id),
    .tx_payload(tx_payload), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_payload(rx_payload), .rx_pos(rx_pos), .rx_vel(rx_vel), .rx_trq(rx_trq),
    .rx_err(rx_err));
  task end_sim;
  begin
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask
  // one request, then wait for its answer under a bound
  task req(input logic [2:0] op, input logic [3:0] id);
  begin
    // one idle edge keeps back-to-back requests from sharing a time step
    @(posedge clk) #1;
    req_valid = 1'b1;
    req_op = op;
    req_id = id;
    req_payload = {16{id}};
    @(posedge clk);
    #1 req_valid = 1'b0;
    for (k = 0; k < 3000 && ans_valid !== 1'b1; k = k + 1)
      @(posedge clk) #1;
    chk(ans_valid, 1);
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #400000;
    n_errors = n_errors + 1;
    end_sim;
  end
  initial
  begin
    {n_errors, check_count} = 0;
    {reset, req_valid, req_op, req_id, req_payload, rd_slot} = {1'b1, 76'h0};
    rows = '{{3'h5, 4'h0, 2'h0}, {3'h5, 4'h1, 2'h0}, {3'h5, 4'h2, 2'h0}, {3'h5, 4'h3, 2'h0},
             {3'h0, 4'h2, 2'h0}, {3'h0, 4'h5, 2'h1}, {3'h2, 4'h2, 2'h0}, {3'h2, 4'h5, 2'h1},
             {3'h2, 4'h9, 2'h0}, {3'h1, 4'h0, 2'h0}, {3'h6, 4'h0, 2'h0}};
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    for (i = 0; i < 11; i = i + 1)
    begin
      req(rows[i].op, rows[i].id);
      chk(ans_status, rows[i].st);
      if (rows[i].op == 3'h5) chk(rate_q, rows[i].id[1:0]);
      if (rows[i].op == 3'h0 && rows[i].st == 2'h0) chk(ans_payload, ~{16{rows[i].id}});
      if (rows[i].op == 3'h1) chk(ans_id_map, PRES);
      $display("row %0d done", i);
    end
    chk(list_count_q, 2);
    // relay rows stand in for drive setup, all done before begin
    req(3'h3, 4'h0);
    chk(update_mode_q, 1);
    for (k = 0; k < FR + 20 && fresh_q !== 1'b1; k = k + 1)
      @(posedge clk) #1;
    chk(fresh_q, 1);
    for (i = 0; i < 2; i = i + 1)
    begin
      rd_slot = i ? 4'h9 : 4'h2;
      repeat (2) @(posedge clk);
      #1 chk(rd_pos, i ? 32'h9 : 32'h2);
      chk(rd_vel, i ? 32'hFFFFFFF6 : 32'hFFFFFFFD);
      chk(rd_trq, i ? 32'h90000000 : 32'h20000000);
      chk(rd_err, i ? 16'h9 : 16'h2);
    end
    $display("update data done");
    req(3'h0, 4'h2);
    chk(ans_status, 2);
    req(3'h2, 4'h9);
    chk(ans_status, 2);
    chk(update_mode_q, 1);
    req(3'h4, 4'h0);
    chk(update_mode_q, 0);
    req(3'h3, 4'h0);
    chk(update_mode_q, 1);
    $display("refuse and resume done");
    // reset while cycling must drop back to a clean config state
    reset = 1'b1;
    @(posedge clk) #1;
    chk({update_mode_q, rate_q, list_count_q}, 0);
    reset = 1'b0;
    @(posedge clk) #1;
    chk({update_mode_q, rate_q, list_count_q, tx_valid}, 0);
    $display("reset done");
    end_sim;
  end
endmodule
